// ---- rtl/framer_misc_control_regs.sv ----
// per-channel framer control registers behind a classic wishbone slave
// assumes events, busy and mode inputs come from logic on i_clk
//
// Notes on behaviour
// - clear mode 0: reading status clears every status bit that was read set.
// - clear mode 1: status holds over reads, cleared by writing ones.
// - autoclear 0: interrupt enables are untouched by status reads.
// - autoclear 1: status read forces matching enable bits to zero.
// - framer interrupt enable at 0 blocks every interrupt from the channel.
// - bit-oriented controller disabled mid-message aborts and sends all ones.
// - message-oriented controller disabled mid-message sends repeated flags instead.
// - select code 00 and 11 pick controller one, 01 two, 10 three.
// - loss-of-signal output enable at 0 keeps the pin undriven always.
// - enable at 1 drives pin high on signal loss, low otherwise.
// - rate bit 0 selects standard 1.544 and 2.048 MHz reference clocks.
// - rate bit 1 selects 49.408 and 65.536 MHz reference clocks.
//
// Decided for this implementation: the Wishbone register port.
`include "framer_misc_regs.svh"

module framer_misc_control_regs
  import framer_misc_pkg::*;
(
  // clock, reset, enable
  input  wire logic                    i_clk,
  input  wire logic                    i_rst,
  input  wire logic                    i_ce,
  // wishbone slave
  input  wire logic                    i_wb_cyc,
  input  wire logic                    i_wb_stb,
  input  wire logic                    i_wb_we,
  input  wire logic [11:0]             i_wb_adr,
  input  wire logic [3:0]              i_wb_sel,
  input  wire logic [31:0]             i_wb_dat,
  output logic      [31:0]             o_wb_dat,
  output logic                         o_wb_ack,
  // framer events and interrupt
  input  wire logic [`NUM_EVENTS-1:0]  i_evt,
  output logic                         o_irq,
  // data-link controllers
  input  wire logic [`NUM_DL-1:0]      i_dl_busy,
  input  wire logic [`NUM_DL-1:0]      i_dl_bit_oriented,
  input  wire logic                    i_dl_bit_tick,
  output logic      [`NUM_DL-1:0]      o_dl_enable,
  output logic      [`NUM_DL-1:0]      o_dl_selected,
  output logic      [`NUM_DL-1:0]      o_dl_abort,
  output logic      [`NUM_DL-1:0]      o_dl_fill_bit,
  // loss-of-signal pin and reference clock rate
  input  wire logic                    i_rx_los,
  output logic                         o_rx_los_pin,
  output logic                         o_rx_los_pin_oe,
  output logic                         o_ref_clock_rate_sel
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [9:0] idx, input logic [9:0] adr);
    hit = (idx == adr);
  endfunction

  // controller select code to one-hot
  function automatic logic [`NUM_DL-1:0] sel_decode(input logic [1:0] code);
    case (code)
      2'h1:    sel_decode = 3'h2;
      2'h2:    sel_decode = 3'h4;
      default: sel_decode = 3'h1;
    endcase
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [2:0]              intctl_r;
  logic [2:0]              intctl_nxt;
  logic [`NUM_DL-1:0]      dl_en_r;
  logic [`NUM_DL-1:0]      dl_en_nxt;
  logic [1:0]              dl_sel_r;
  logic [1:0]              dl_sel_nxt;
  logic                    los_oe_r;
  logic                    los_oe_nxt;
  logic                    rate_r;
  logic                    rate_nxt;
  logic [`NUM_EVENTS-1:0]  ist_r;
  logic [`NUM_EVENTS-1:0]  ist_nxt;
  logic [`NUM_EVENTS-1:0]  ien_r;
  logic [`NUM_EVENTS-1:0]  ien_nxt;
  logic                    ack_r;
  logic                    ack_nxt;
  logic [31:0]             rdat_r;
  logic [31:0]             rdat_nxt;
  logic                    irq_r;
  logic                    irq_nxt;
  logic                    los_pin_r;
  logic                    los_pin_nxt;
  logic                    los_pin_oe_r;
  logic                    los_pin_oe_nxt;
  dl_state_t               dl_st_r  [`NUM_DL];
  dl_state_t               dl_st_nxt[`NUM_DL];
  logic [2:0]              flag_pos_r;
  logic [2:0]              flag_pos_nxt;
  logic [`NUM_DL-1:0]      abort_r;
  logic [`NUM_DL-1:0]      abort_nxt;
  logic [`NUM_DL-1:0]      fill_r;
  logic [`NUM_DL-1:0]      fill_nxt;
  logic [`NUM_DL-1:0]      selected_r;
  logic [`NUM_DL-1:0]      selected_nxt;

  // ****************************************
  // bus decode
  // ****************************************
  logic        acc;
  logic        rd;
  logic        wr;
  logic [9:0]  widx;
  logic [7:0]  wbyte;

  assign acc   = i_wb_cyc & i_wb_stb & ~ack_r;
  assign rd    = acc & ~i_wb_we;
  assign wr    = acc & i_wb_we & i_wb_sel[0];
  assign widx  = i_wb_adr[11:2];
  assign wbyte = i_wb_dat[7:0];

  // ****************************************
  // register file next values
  // ****************************************
  always_comb
  begin
    logic [`NUM_EVENTS-1:0] clr;
    clr        = '0;
    intctl_nxt = intctl_r;
    dl_en_nxt  = dl_en_r;
    dl_sel_nxt = dl_sel_r;
    los_oe_nxt = los_oe_r;
    rate_nxt   = rate_r;
    ien_nxt    = ien_r;
    ack_nxt    = acc;
    rdat_nxt   = '0;
    if (wr)
    begin
      if (hit(`IDX_INTERRUPT_CONTROL, widx))
        intctl_nxt = wbyte[2:0];
      if (hit(`IDX_DL_SELECT, widx))
      begin
        dl_en_nxt  = wbyte[`DLS_ENABLE_MSB:`DLS_ENABLE_LSB];
        dl_sel_nxt = wbyte[`DLS_SELECT_MSB:0];
      end
      if (hit(`IDX_PERF_REPORT_CTRL, widx))
        los_oe_nxt = wbyte[`PERF_LOS_OE_BIT];
      if (hit(`IDX_GAPPED_CLOCK_CTRL, widx))
        rate_nxt = wbyte[`GAPCLK_RATE_BIT];
      if (hit(`IDX_INTERRUPT_ENABLE, widx))
        ien_nxt = wbyte;
      // write-to-clear only in clear mode 1
      if (hit(`IDX_INTERRUPT_STATUS, widx) && intctl_r[`INTCTL_CLEAR_MODE_BIT])
        clr = wbyte;
    end
    if (rd && hit(`IDX_INTERRUPT_STATUS, widx))
    begin
      // reset upon read in clear mode 0
      if (!intctl_r[`INTCTL_CLEAR_MODE_BIT])
        clr = ist_r;
      if (intctl_r[`INTCTL_AUTOCLEAR_BIT])
        ien_nxt = ien_r & ~ist_r;
    end
    if (rd)
    begin
      case (widx)
        `IDX_INTERRUPT_STATUS:  rdat_nxt[7:0] = ist_r;
        `IDX_INTERRUPT_ENABLE:  rdat_nxt[7:0] = ien_r;
        `IDX_INTERRUPT_CONTROL: rdat_nxt[2:0] = intctl_r;
        `IDX_DL_SELECT:         rdat_nxt[4:0] = {dl_en_r, dl_sel_r};
        `IDX_PERF_REPORT_CTRL:  rdat_nxt[`PERF_LOS_OE_BIT] = los_oe_r;
        `IDX_GAPPED_CLOCK_CTRL: rdat_nxt[`GAPCLK_RATE_BIT] = rate_r;
        default:                rdat_nxt = '0;
      endcase
    end
    // new events win over a clear in the same cycle
    ist_nxt = (ist_r & ~clr) | i_evt;
    irq_nxt = intctl_nxt[`INTCTL_IRQ_ENABLE_BIT] & (|(ist_nxt & ien_nxt));
    los_pin_oe_nxt = los_oe_nxt;
    // high on loss, low with data
    los_pin_nxt = los_oe_nxt & i_rx_los;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      intctl_r     <= `INTCTL_RESET;
      dl_en_r      <= `DLS_ENABLE_RESET;
      dl_sel_r     <= `DLS_SELECT_RESET;
      los_oe_r     <= `LOS_OE_RESET;
      rate_r       <= `RATE_RESET;
      ist_r        <= '0;
      ien_r        <= '0;
      ack_r        <= 1'b0;
      rdat_r       <= '0;
      irq_r        <= 1'b0;
      los_pin_r    <= 1'b0;
      los_pin_oe_r <= `LOS_OE_RESET;
    end
    else if (i_ce)
    begin
      intctl_r     <= intctl_nxt;
      dl_en_r      <= dl_en_nxt;
      dl_sel_r     <= dl_sel_nxt;
      los_oe_r     <= los_oe_nxt;
      rate_r       <= rate_nxt;
      ist_r        <= ist_nxt;
      ien_r        <= ien_nxt;
      ack_r        <= ack_nxt;
      rdat_r       <= rdat_nxt;
      irq_r        <= irq_nxt;
      los_pin_r    <= los_pin_nxt;
      los_pin_oe_r <= los_pin_oe_nxt;
    end
  end

  // ****************************************
  // data-link controller fill
  // ****************************************
  // a single flag phase is shared; flags from all controllers align with each other
  always_comb
  begin
    flag_pos_nxt = flag_pos_r;
    if (i_dl_bit_tick)
      flag_pos_nxt = flag_pos_r + 3'h1;
    selected_nxt = sel_decode(dl_sel_nxt);
    for (int k = 0; k < `NUM_DL; k++)
    begin
      dl_st_nxt[k] = dl_st_r[k];
      case (dl_st_r[k])
        DL_ON:
        begin
          if (!dl_en_nxt[k])
          begin
            if (!i_dl_busy[k])
              dl_st_nxt[k] = DL_OFF_IDLE;
            else if (i_dl_bit_oriented[k])
              dl_st_nxt[k] = DL_OFF_ONES;
            else
              dl_st_nxt[k] = DL_OFF_FLAGS;
          end
        end
        DL_OFF_IDLE, DL_OFF_ONES, DL_OFF_FLAGS:
        begin
          if (dl_en_nxt[k])
            dl_st_nxt[k] = DL_ON;
        end
        default: dl_st_nxt[k] = DL_ON;
      endcase
      abort_nxt[k] = (dl_st_nxt[k] == DL_OFF_ONES) || (dl_st_nxt[k] == DL_OFF_FLAGS);
      // flag bits while aborted in message mode
      if (dl_st_nxt[k] == DL_OFF_FLAGS)
        fill_nxt[k] = 1'(`FLAG_PATTERN >> flag_pos_nxt);
      else
        fill_nxt[k] = 1'b1;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      flag_pos_r <= 3'h0;
      selected_r <= 3'h1;
      abort_r    <= '0;
      fill_r     <= '1;
      for (int k = 0; k < `NUM_DL; k++)
        dl_st_r[k] <= DL_ON;
    end
    else if (i_ce)
    begin
      flag_pos_r <= flag_pos_nxt;
      selected_r <= selected_nxt;
      abort_r    <= abort_nxt;
      fill_r     <= fill_nxt;
      for (int k = 0; k < `NUM_DL; k++)
        dl_st_r[k] <= dl_st_nxt[k];
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign o_wb_dat        = rdat_r;
  assign o_wb_ack        = ack_r;
  assign o_irq           = irq_r;
  assign o_dl_enable     = dl_en_r;
  assign o_dl_selected   = selected_r;
  assign o_dl_abort      = abort_r;
  assign o_dl_fill_bit   = fill_r;
  assign o_rx_los_pin    = los_pin_r;
  assign o_rx_los_pin_oe = los_pin_oe_r;
  // rate bit 0 keeps standard rates
  // rate bit 1 asks the clock generator for high rates
  assign o_ref_clock_rate_sel = rate_r;

endmodule // framer_misc_control_regs

// ---- rtl/framer_misc_pkg.sv ----
// types shared by the framer control group
// assumes framer_misc_regs.svh supplies the numeric constants
package framer_misc_pkg;

  // per-controller transmit state after an enable change
  typedef enum logic [1:0] {
    DL_ON,
    DL_OFF_IDLE,
    DL_OFF_ONES,
    DL_OFF_FLAGS
  } dl_state_t;

endpackage

// ---- rtl/framer_misc_regs.svh ----
// register offsets, field positions and reset values of the framer control group
// assumes a 32-bit wishbone slave with registers in the low byte of each word
`ifndef FRAMER_MISC_REGS_SVH
`define FRAMER_MISC_REGS_SVH

// ****************************************
// register indices (byte address = 4 * index)
// ****************************************
`define IDX_INTERRUPT_STATUS   10'h118
`define IDX_INTERRUPT_ENABLE   10'h119
`define IDX_INTERRUPT_CONTROL  10'h11a
`define IDX_DL_SELECT          10'h11b
`define IDX_PERF_REPORT_CTRL   10'h11c
`define IDX_GAPPED_CLOCK_CTRL  10'h11d

// ****************************************
// field positions
// ****************************************
`define INTCTL_CLEAR_MODE_BIT  2
`define INTCTL_AUTOCLEAR_BIT   1
`define INTCTL_IRQ_ENABLE_BIT  0
`define DLS_ENABLE_LSB         2
`define DLS_ENABLE_MSB         4
`define DLS_SELECT_MSB         1
`define PERF_LOS_OE_BIT        6
`define GAPCLK_RATE_BIT        7

// ****************************************
// reset values and constants
// ****************************************
`define INTCTL_RESET           3'h0
`define DLS_ENABLE_RESET       3'h7
`define DLS_SELECT_RESET       2'h0
`define LOS_OE_RESET           1'h1
`define RATE_RESET             1'h0
`define FLAG_PATTERN           8'h7e
`define NUM_EVENTS             8
`define NUM_DL                 3

`endif

// ---- verification/framer_misc_control_regs_monitor.sv ----
// concurrent checks on the framer control group ports
// assumes bind to the top module and one clock domain
`include "framer_misc_regs.svh"

module framer_misc_control_regs_monitor (
  // clock and reset
  input wire logic        i_clk,
  input wire logic        i_rst,
  // bus
  input wire logic        i_ce,
  input wire logic        i_wb_cyc,
  input wire logic        i_wb_stb,
  input wire logic        i_wb_we,
  input wire logic [11:0] i_wb_adr,
  input wire logic [3:0]  i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  input wire logic        o_wb_ack,
  // framer side
  input wire logic        o_irq,
  input wire logic [2:0]  i_dl_busy,
  input wire logic [2:0]  i_dl_bit_oriented,
  input wire logic [2:0]  o_dl_enable,
  input wire logic [2:0]  o_dl_selected,
  input wire logic [2:0]  o_dl_abort,
  input wire logic [2:0]  o_dl_fill_bit,
  input wire logic        i_rx_los,
  input wire logic        o_rx_los_pin,
  input wire logic        o_rx_los_pin_oe,
  input wire logic        o_ref_clock_rate_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take, wr, irq_en_r, irq_en_nxt;
  logic [2:0] dec;
  assign take = i_ce & i_wb_cyc & i_wb_stb & ~o_wb_ack;
  assign wr   = take & i_wb_we & i_wb_sel[0];
  assign dec  = (i_wb_dat[1:0] == 2'h1) ? 3'h2 : (i_wb_dat[1:0] == 2'h2) ? 3'h4 : 3'h1;
  // shadow of the irq enable, as the gate itself is not visible at the ports
  always_comb
  begin
    irq_en_nxt = irq_en_r;
    if (wr && i_wb_adr[11:2] == `IDX_INTERRUPT_CONTROL)
      irq_en_nxt = i_wb_dat[`INTCTL_IRQ_ENABLE_BIT];
  end
  always_ff @(posedge i_clk or posedge i_rst)
    if (i_rst)
      irq_en_r <= 1'h0;
    else
      irq_en_r <= irq_en_nxt;

  default clocking @(posedge i_clk);
  endclocking
  default disable iff (i_rst);

  sequence s_wr(logic [9:0] idx);
    wr && i_wb_adr[11:2] == idx;
  endsequence
  sequence s_flags;
    o_dl_abort[1] ##[1:20] !o_dl_fill_bit[1];
  endsequence

  a_ack_answer: assert property (take |=> o_wb_ack)
    else $error("request not answered next cycle");
  a_ack_drop: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack stands longer than one cycle");
  a_irq_gate: assert property (!irq_en_r |-> !o_irq)
    else $error("irq raised while framer irq disabled");
  a_dl_enable: assert property (s_wr(`IDX_DL_SELECT)
    |=> o_dl_enable == $past(i_wb_dat[`DLS_ENABLE_MSB:`DLS_ENABLE_LSB]))
    else $error("controller enables not taken from write");
  a_dl_select: assert property (s_wr(`IDX_DL_SELECT) |=> o_dl_selected == $past(dec))
    else $error("controller select decode wrong");
  a_bit_ones: assert property (s_wr(`IDX_DL_SELECT) ##0 (!i_wb_dat[2] && i_dl_busy[0] &&
    i_dl_bit_oriented[0] && o_dl_enable[0]) |=> o_dl_abort[0] && o_dl_fill_bit[0])
    else $error("bit-oriented abort does not send ones");
  a_msg_flags: assert property (s_wr(`IDX_DL_SELECT) ##0 (!i_wb_dat[3] && i_dl_busy[1] &&
    !i_dl_bit_oriented[1] && o_dl_enable[1]) |=> s_flags)
    else $error("message-oriented abort does not send flags");
  a_los_oe: assert property (s_wr(`IDX_PERF_REPORT_CTRL)
    |=> o_rx_los_pin_oe == $past(i_wb_dat[`PERF_LOS_OE_BIT]))
    else $error("los pin enable not taken from write");
  a_los_follow: assert property (o_rx_los_pin_oe && $past(o_rx_los_pin_oe) && !$past(i_rst)
    |-> o_rx_los_pin == $past(i_rx_los))
    else $error("los pin does not follow detector");
  a_rate_sel: assert property (s_wr(`IDX_GAPPED_CLOCK_CTRL)
    |=> o_ref_clock_rate_sel == $past(i_wb_dat[`GAPCLK_RATE_BIT]))
    else $error("clock rate select not taken from write");
endmodule // framer_misc_control_regs_monitor

bind framer_misc_control_regs framer_misc_control_regs_monitor i_mon (
  .i_clk, .i_rst, .i_ce, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr, .i_wb_sel, .i_wb_dat,
  .o_wb_ack, .o_irq, .i_dl_busy, .i_dl_bit_oriented, .o_dl_enable, .o_dl_selected, .o_dl_abort,
  .o_dl_fill_bit, .i_rx_los, .o_rx_los_pin, .o_rx_los_pin_oe, .o_ref_clock_rate_sel);

// ---- verification/framer_misc_control_regs_test.sv ----
// self-checking bench for the framer control group
// assumes the checker is bound separately; clock enable held high
`include "framer_misc_regs.svh"
`define CHK(nm, e, g) checks_done++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end

module framer_misc_control_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        i_clk = 1'h0, i_rst = 1'h1, i_wb_cyc = 1'h0, i_wb_stb = 1'h0, i_wb_we = 1'h0;
  logic        i_dl_bit_tick = 1'h0, i_rx_los = 1'h0;
  logic        o_wb_ack, o_irq, o_rx_los_pin, o_rx_los_pin_oe, o_ref_clock_rate_sel;
  logic [11:0] i_wb_adr = 12'h0;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, q;
  logic [7:0]  i_evt = 8'h0;
  logic [2:0]  i_dl_busy = 3'h0, i_dl_bit_oriented = 3'h0;
  logic [2:0]  o_dl_enable, o_dl_selected, o_dl_abort, o_dl_fill_bit;
  logic [7:0]  cfg_outs;
  int          failures, checks_done, n;
  typedef struct packed { logic w; logic [9:0] idx; logic [7:0] wd, rd, outs; } row_t;
  // reset rows first (no write), outs = {enables, selected, los oe, rate}
  row_t rows [15] = '{
    '{1'h0, `IDX_INTERRUPT_CONTROL, 8'h00, 8'h00, 8'he6},
    '{1'h0, `IDX_DL_SELECT, 8'h00, 8'h1c, 8'he6},
    '{1'h0, `IDX_PERF_REPORT_CTRL, 8'h00, 8'h40, 8'he6},
    '{1'h0, `IDX_GAPPED_CLOCK_CTRL, 8'h00, 8'h00, 8'he6},
    '{1'h1, `IDX_DL_SELECT, 8'h00, 8'h00, 8'h06},
    '{1'h1, `IDX_DL_SELECT, 8'h1d, 8'h1d, 8'hea},
    '{1'h1, `IDX_DL_SELECT, 8'h1e, 8'h1e, 8'hf2},
    '{1'h1, `IDX_DL_SELECT, 8'hff, 8'h1f, 8'he6},
    '{1'h1, `IDX_GAPPED_CLOCK_CTRL, 8'h80, 8'h80, 8'he7},
    '{1'h1, `IDX_INTERRUPT_CONTROL, 8'hff, 8'h07, 8'he7},
    '{1'h1, `IDX_INTERRUPT_CONTROL, 8'h00, 8'h00, 8'he7},
    '{1'h1, `IDX_PERF_REPORT_CTRL, 8'hbf, 8'h00, 8'he5},
    '{1'h1, `IDX_PERF_REPORT_CTRL, 8'h40, 8'h40, 8'he7},
    '{1'h1, 10'h120, 8'hff, 8'h00, 8'he7},
    '{1'h1, `IDX_GAPPED_CLOCK_CTRL, 8'h00, 8'h00, 8'he6}};

  framer_misc_control_regs i_dut (.i_clk, .i_rst, .i_ce(1'h1), .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_sel(4'hf), .i_wb_dat, .o_wb_dat, .o_wb_ack, .i_evt, .o_irq, .i_dl_busy,
    .i_dl_bit_oriented, .i_dl_bit_tick, .o_dl_enable, .o_dl_selected, .o_dl_abort, .o_dl_fill_bit,
    .i_rx_los, .o_rx_los_pin, .o_rx_los_pin_oe, .o_ref_clock_rate_sel);
  assign cfg_outs = {o_dl_enable, o_dl_selected, o_rx_los_pin_oe, o_ref_clock_rate_sel};

  initial forever #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) i_dl_bit_tick <= ~i_dl_bit_tick;

  // *****
  // bus, event pulse and closing tasks
  // *****
  task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    @(posedge i_clk);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we  <= w;
    i_wb_adr <= {idx, 2'h0};
    i_wb_dat <= {24'h0, d};
    n = 0;
    @(posedge i_clk);
    while (o_wb_ack !== 1'h1 && n++ < 20) @(posedge i_clk);
    if (n > 20) failures++;
    q = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
  endtask

  task automatic pulse(input logic [7:0] e);
    @(posedge i_clk);
    i_evt <= e;
    @(posedge i_clk);
    i_evt <= 8'h00;
    repeat (2) @(posedge i_clk);
  endtask

  task report_and_stop;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // a generous ceiling; the run needs well under a thousand cycles
  initial
  begin
    repeat (3000) @(posedge i_clk);
    failures++;
    report_and_stop();
  end

  initial
  begin
    repeat (12) @(posedge i_clk);
    i_rst <= 1'h0;
    foreach (rows[i])
    begin
      if (rows[i].w) wb(1'h1, rows[i].idx, rows[i].wd);
      wb(1'h0, rows[i].idx, 8'h00);
      `CHK("readback", {24'h0, rows[i].rd}, q)
      `CHK("outputs", rows[i].outs, cfg_outs)
    end
    wb(1'h1, `IDX_INTERRUPT_ENABLE, 8'hff);
    pulse(8'h05);
    `CHK("irq off", 1'h0, o_irq)
    wb(1'h0, `IDX_INTERRUPT_STATUS, 8'h00);
    `CHK("status", 32'h05, q)
    wb(1'h0, `IDX_INTERRUPT_STATUS, 8'h00);
    `CHK("status", 32'h00, q)
    wb(1'h0, `IDX_INTERRUPT_ENABLE, 8'h00);
    `CHK("enable", 32'hff, q)
    wb(1'h1, `IDX_INTERRUPT_CONTROL, 8'h07);
    pulse(8'h03);
    `CHK("irq on", 1'h1, o_irq)
    wb(1'h0, `IDX_INTERRUPT_STATUS, 8'h00);
    `CHK("status", 32'h03, q)
    wb(1'h0, `IDX_INTERRUPT_STATUS, 8'h00);
    `CHK("status", 32'h03, q)
    wb(1'h0, `IDX_INTERRUPT_ENABLE, 8'h00);
    `CHK("enable", 32'hfc, q)
    `CHK("irq", 1'h0, o_irq)
    wb(1'h1, `IDX_INTERRUPT_STATUS, 8'h01);
    wb(1'h0, `IDX_INTERRUPT_STATUS, 8'h00);
    `CHK("status", 32'h02, q)
    i_dl_busy <= 3'h7;
    i_dl_bit_oriented <= 3'h1;
    wb(1'h1, `IDX_DL_SELECT, 8'h1c);
    `CHK("abort", 3'h0, o_dl_abort)
    wb(1'h1, `IDX_DL_SELECT, 8'h00);
    `CHK("abort", 3'h7, o_dl_abort)
    `CHK("ones", 1'h1, o_dl_fill_bit[0])
    n = 0;
    repeat (20) @(posedge i_clk) n += (o_dl_fill_bit[1] === 1'h0);
    `CHK("flags", 1'h1, n > 0 && n < 20)
    i_dl_busy <= 3'h0;
    wb(1'h1, `IDX_PERF_REPORT_CTRL, 8'h40);
    @(posedge i_clk) i_rx_los <= 1'h1;
    repeat (2) @(posedge i_clk);
    `CHK("los pin", 2'h3, {o_rx_los_pin_oe, o_rx_los_pin})
    @(posedge i_clk) i_rx_los <= 1'h0;
    repeat (2) @(posedge i_clk);
    `CHK("los pin", 2'h2, {o_rx_los_pin_oe, o_rx_los_pin})
    wb(1'h1, `IDX_PERF_REPORT_CTRL, 8'h00);
    @(posedge i_clk) i_rx_los <= 1'h1;
    repeat (2) @(posedge i_clk);
    `CHK("los off", 2'h0, {o_rx_los_pin_oe, o_rx_los_pin})
    // mid-run reset must bring every output except the los pin and read data back to its idle value
    i_rst <= 1'h1;
    repeat (2) @(posedge i_clk);
    i_rst <= 1'h0;
    @(posedge i_clk);
    `CHK("reset outs", 8'he6, cfg_outs)
    `CHK("reset fill", 6'h07, {o_dl_abort, o_dl_fill_bit})
    `CHK("reset irq", 2'h0, {o_irq, o_wb_ack})
    report_and_stop();
  end
endmodule // framer_misc_control_regs_test
